// File: src/host_port_regs.svh
// constants for the shared-bus host port and the configuration rom pins
`ifndef HOST_PORT_REGS_SVH
`define HOST_PORT_REGS_SVH
`define CLK_PERIOD_PS        32'd8000
`define ROM_PERIOD_SLOW_PS   32'd4000000
`define ROM_PERIOD_FAST_PS   32'd800000
`define ROM_HALF_SLOW        ((`ROM_PERIOD_SLOW_PS / `CLK_PERIOD_PS) / 32'd2)
`define ROM_HALF_FAST        ((`ROM_PERIOD_FAST_PS / `CLK_PERIOD_PS) / 32'd2)
`define SPEED_25MHZ          2'h3
`define SPEED_125MHZ         2'h0
`define ADDR_LSB             2
`define ADDR_MSB             7
`define BE_LSB               12
`define BE_MSB               15
`define ROM_BITS             6'd32
`endif

// File: src/host_port_pkg.sv
// types used by the controller end of the host port
package host_port_pkg;
    typedef enum logic [1:0] {ACC_IDLE, ACC_ADDR, ACC_WRITE, ACC_READ} acc_kind_t;
endpackage

// File: src/host_port_if.sv
// shared bus, strobes and rom pins between host and controller
`timescale 1ns/10ps
interface host_port_if;
    logic        chip_select_n;
    logic        write_strobe_n;
    logic        read_strobe_n;
    logic        cmd_type;
    logic [15:0] host_bus_o;
    logic        host_bus_oe;
    logic [15:0] dev_bus_o;
    logic        dev_bus_oe;
    logic        cfg_rom_clock;
    logic        cfg_rom_select;
    logic        cfg_rom_data_o;
    logic        cfg_rom_data_oe;
    logic        cfg_rom_data_i;
    logic        rom_clock_pull;
    logic        rom_data_pull;
    logic        link_led_zero;
    logic        led_pull;
    modport host (output chip_select_n, write_strobe_n, read_strobe_n, cmd_type,
                  host_bus_o, host_bus_oe, input dev_bus_o, dev_bus_oe);
    modport dev (input chip_select_n, write_strobe_n, read_strobe_n, cmd_type,
                 host_bus_o, host_bus_oe, rom_clock_pull, rom_data_pull, led_pull,
                 cfg_rom_data_i,
                 output dev_bus_o, dev_bus_oe, cfg_rom_clock, cfg_rom_select,
                 cfg_rom_data_o, cfg_rom_data_oe, link_led_zero);
endinterface

// File: src/host_port_dev.sv
// controller end: bus decode, register file, straps and rom serial engine
`timescale 1ns/10ps
`include "host_port_regs.svh"
module host_port_dev #(
    parameter int NREG = 64
) (
    input  wire logic  core_clk_i,        // 125 MHz clock
    input  wire logic  sys_rst_i,         // sync reset, high
    host_port_if.dev   bus,               // shared bus and rom pins
    input  wire logic [1:0] bus_speed_i,  // onchip_bus_speed_ctrl field
    input  wire logic  rom_start_i,       // start one rom transfer
    input  wire logic [31:0] rom_word_i,  // word shifted out to rom
    output logic       rom_busy_o,        // rom transfer in progress
    output logic [31:0] rom_rdata_o,      // word shifted in from rom
    output logic       rom_present_o,     // strap: rom fitted
    output logic       big_endian_o,      // strap: byte order
    output logic       bus_is16_o,        // strap: 16-bit host bus
    output logic [7:0] last_addr_o,       // last decoded address
    output logic [3:0] last_be_o          // last byte enables
);
    logic [15:0] regs [NREG];
    logic [7:0]  addr;
    logic [3:0]  be;
    logic        in_reset;
    logic        wr_q;
    logic        rd_q;
    logic [31:0] half_cnt;
    logic [5:0]  bit_cnt;
    logic [31:0] shreg;

    function automatic host_port_pkg::acc_kind_t decode(input logic cs_n, input logic wr_n,
                                                        input logic rd_n, input logic cmd);
        if (cs_n)
            return host_port_pkg::ACC_IDLE;
        else if (cmd && !wr_n)
            return host_port_pkg::ACC_ADDR;
        else if (!wr_n)
            return host_port_pkg::ACC_WRITE;
        else if (!rd_n)
            return host_port_pkg::ACC_READ;
        return host_port_pkg::ACC_IDLE;
    endfunction

    host_port_pkg::acc_kind_t kind;
    assign kind = decode(bus.chip_select_n, bus.write_strobe_n, bus.read_strobe_n,
                         bus.cmd_type);

    // straps sampled while reset is held, frozen after release
    always_ff @(posedge core_clk_i)
    begin
        in_reset <= sys_rst_i;
        if (sys_rst_i)
        begin
            rom_present_o <= bus.rom_data_pull;
            big_endian_o  <= bus.rom_clock_pull;
            bus_is16_o    <= bus.led_pull;
        end
    end

    // address phase latched every cycle chip select and the write strobe are low with cmd_type high
    always_ff @(posedge core_clk_i)
    begin
        wr_q <= sys_rst_i ? 1'b0 : (kind == host_port_pkg::ACC_WRITE);
        rd_q <= sys_rst_i ? 1'b0 : (kind == host_port_pkg::ACC_READ);
        if (sys_rst_i)
        begin
            addr <= 8'h00;
            be   <= 4'h0;
        end
        else if (kind == host_port_pkg::ACC_ADDR)
        begin
            if (bus_is16_o)
            begin
                addr <= {bus.host_bus_o[`ADDR_MSB:`ADDR_LSB], 2'h0};
                be   <= bus.host_bus_o[`BE_MSB:`BE_LSB];
            end
            else
            begin
                addr <= bus.host_bus_o[7:0];
                be   <= 4'h1;
            end
        end
    end

    // one write per strobe low edge; 8-bit mode writes the low byte only
    always_ff @(posedge core_clk_i)
    begin
        if (kind == host_port_pkg::ACC_WRITE && !wr_q)
        begin
            if (bus_is16_o)
                regs[addr[7:1] % NREG] <= bus.host_bus_o;
            else
                regs[addr[7:1] % NREG][7:0] <= bus.host_bus_o[7:0];
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            bus.dev_bus_o  <= 16'h0000;
            bus.dev_bus_oe <= 1'b0;
        end
        else
        begin
            bus.dev_bus_oe <= (kind == host_port_pkg::ACC_READ);
            bus.dev_bus_o  <= bus_is16_o ? regs[addr[7:1] % NREG]
                                         : {8'h00, regs[addr[7:1] % NREG][7:0]};
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        last_addr_o <= sys_rst_i ? 8'h00 : addr;
        last_be_o   <= sys_rst_i ? 4'h0 : be;
    end

    // rom serial engine: half period chosen by bus speed field
    logic [31:0] half_lim;
    assign half_lim = (bus_speed_i == `SPEED_25MHZ) ? `ROM_HALF_SLOW : `ROM_HALF_FAST;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            rom_busy_o        <= 1'b0;
            half_cnt          <= 32'd0;
            bit_cnt           <= 6'd0;
            shreg             <= 32'h0000_0000;
            rom_rdata_o       <= 32'h0000_0000;
            bus.cfg_rom_clock <= 1'b0;
            bus.cfg_rom_select <= 1'b0;
        end
        else if (!rom_busy_o)
        begin
            bus.cfg_rom_clock <= 1'b0;
            if (rom_start_i)
            begin
                rom_busy_o         <= 1'b1;
                bus.cfg_rom_select <= 1'b1;
                shreg              <= rom_word_i;
                bit_cnt            <= 6'd0;
                half_cnt           <= 32'd0;
            end
        end
        else if (half_cnt == half_lim - 32'd1)
        begin
            half_cnt          <= 32'd0;
            bus.cfg_rom_clock <= ~bus.cfg_rom_clock;
            if (bus.cfg_rom_clock)
            begin
                shreg   <= {shreg[30:0], bus.cfg_rom_data_i};
                bit_cnt <= bit_cnt + 6'd1;
                if (bit_cnt == `ROM_BITS - 6'd1)
                begin
                    rom_busy_o         <= 1'b0;
                    bus.cfg_rom_select <= 1'b0;
                    rom_rdata_o        <= {shreg[30:0], bus.cfg_rom_data_i};
                end
            end
        end
        else
            half_cnt <= half_cnt + 32'd1;
    end

    // rom data pin is an input in reset and the cycle after, an output while rom_busy_o delayed by one cycle; led pin high in reset, low after
    always_ff @(posedge core_clk_i)
    begin
        bus.cfg_rom_data_oe <= ~sys_rst_i & ~in_reset & rom_busy_o;
        bus.cfg_rom_data_o  <= shreg[31];
        bus.link_led_zero   <= sys_rst_i ? 1'b1 : 1'b0;
    end
endmodule

// File: src/host_port_host.sv
// host end: turns user requests into strobed shared-bus cycles
`timescale 1ns/10ps
`include "host_port_regs.svh"
module host_port_host (
    input  wire logic  core_clk_i,        // 125 MHz clock
    input  wire logic  sys_rst_i,         // sync reset, high
    host_port_if.host  bus,               // shared bus
    input  wire logic  req_i,             // start a request
    input  wire logic  req_write_i,       // 1 write, 0 read
    input  wire logic  mode16_i,          // 16-bit bus width
    input  wire logic [7:0] addr_i,       // register address
    input  wire logic [3:0] be_i,         // byte enables, high active
    input  wire logic [15:0] wdata_i,     // write data
    output logic       busy_o,            // request in progress
    output logic       done_o,            // one-cycle completion
    output logic [15:0] rdata_o           // read data
);
    typedef enum logic [2:0] {S_IDLE, S_ADDR, S_GAP, S_DATA, S_END} hstate_t;
    hstate_t st;
    logic    wr;
    logic [15:0] wd;

    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i)
        begin
            st                 <= S_IDLE;
            busy_o             <= 1'b0;
            done_o             <= 1'b0;
            rdata_o            <= 16'h0000;
            wr                 <= 1'b0;
            wd                 <= 16'h0000;
            bus.chip_select_n  <= 1'b1;
            bus.write_strobe_n <= 1'b1;
            bus.read_strobe_n  <= 1'b1;
            bus.cmd_type       <= 1'b0;
            bus.host_bus_o     <= 16'h0000;
            bus.host_bus_oe    <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            unique case (st)
                S_IDLE:
                    if (req_i)
                    begin
                        st                 <= S_ADDR;
                        busy_o             <= 1'b1;
                        wr                 <= req_write_i;
                        wd                 <= wdata_i;
                        bus.chip_select_n  <= 1'b0;
                        bus.cmd_type       <= 1'b1;
                        bus.write_strobe_n <= 1'b0;
                        bus.host_bus_oe    <= 1'b1;
                        bus.host_bus_o     <= mode16_i ? {be_i, 4'h0, addr_i[7:2], 2'h0}
                                                       : {8'h00, addr_i};
                    end
                S_ADDR:
                begin
                    st                 <= S_GAP;
                    bus.write_strobe_n <= 1'b1;
                end
                S_GAP:
                begin
                    st           <= S_DATA;
                    bus.cmd_type <= 1'b0;
                    if (wr)
                    begin
                        bus.write_strobe_n <= 1'b0;
                        bus.host_bus_o     <= mode16_i ? wd : {8'h00, wd[7:0]};
                    end
                    else
                    begin
                        bus.read_strobe_n <= 1'b0;
                        bus.host_bus_oe   <= 1'b0;
                    end
                end
                S_DATA:
                    st <= S_END;
                S_END:
                begin
                    st                 <= S_IDLE;
                    busy_o             <= 1'b0;
                    done_o             <= 1'b1;
                    if (!wr)
                        rdata_o <= bus.dev_bus_o;
                    bus.write_strobe_n <= 1'b1;
                    bus.read_strobe_n  <= 1'b1;
                    bus.chip_select_n  <= 1'b1;
                    bus.host_bus_oe    <= 1'b0;
                end
            endcase
        end
    end
endmodule

// File: tb/host_port_properties.sv
// checker for the shared bus strobes and the rom pins
`timescale 1ns/10ps
module host_port_properties (
    input wire logic core_clk_i,      // clock
    input wire logic sys_rst_i,       // sync reset
    input wire logic chip_select_n,   // bus select
    input wire logic write_strobe_n,  // write strobe
    input wire logic read_strobe_n,   // read strobe
    input wire logic cmd_type,        // address phase
    input wire logic dev_bus_oe,      // device drives bus
    input wire logic cfg_rom_clock,   // rom clock
    input wire logic cfg_rom_select,  // rom select
    input wire logic cfg_rom_data_oe  // rom data drive
);
    localparam int HALF_FAST = 50;
    localparam int HALF_SLOW = 250;
    logic [8:0] gap;
    logic       seen;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (sys_rst_i);
    // the first edge of a frame is excluded, its gap counts from the select rise and ends at a half period, one above the others
    always_ff @(posedge core_clk_i)
    begin
        if (sys_rst_i || !cfg_rom_select)
        begin
            gap  <= 9'h000;
            seen <= 1'h0;
        end
        else if ($changed(cfg_rom_clock))
        begin
            gap  <= 9'h000;
            seen <= 1'h1;
        end
        else
        begin
            gap <= gap + 9'h001;
        end
    end
    AST_STROBE_NEEDS_SELECT: assert property
        ((!write_strobe_n || !read_strobe_n) |-> !chip_select_n) else $error("strobe without select");
    AST_ONE_STROBE: assert property
        (!(!write_strobe_n && !read_strobe_n)) else $error("both strobes low");
    AST_ADDR_IS_WRITE: assert property
        ((cmd_type && !chip_select_n) |-> read_strobe_n) else $error("read in address phase");
    AST_ADDR_FIRST: assert property
        ($fell(chip_select_n) |-> cmd_type && !write_strobe_n) else $error("no address phase");
    AST_CYCLE_LENGTH: assert property
        ($fell(chip_select_n) |-> (!chip_select_n)[*4] ##1 chip_select_n) else $error("cycle length");
    AST_READ_DRIVE: assert property
        ($fell(read_strobe_n) |=> dev_bus_oe) else $error("no read drive");
    AST_DRIVE_ONLY_ON_READ: assert property
        (dev_bus_oe |-> !$past(read_strobe_n)) else $error("drive without read");
    AST_ROM_HALF_PERIOD: assert property
        ((cfg_rom_select && seen && $changed(cfg_rom_clock))
         |-> (gap == HALF_FAST - 1 || gap == HALF_SLOW - 1)) else $error("rom half period");
    AST_STRAP_PIN_INPUT: assert property
        ($past(sys_rst_i) |-> !cfg_rom_data_oe) else $error("rom data driven in reset");
endmodule

// File: tb/shared_bus_host_port_decode_tb_top.sv
// self-checking bench joining host end and controller end
`timescale 1ns/10ps
module shared_bus_host_port_decode_tb_top;
    typedef struct {
        logic m16; logic [7:0] addr; logic [3:0] be; logic [15:0] wd;
        logic [7:0] amask; logic [15:0] rmask;
    } row_t;
    logic        core_clk_i  = 1'h0;
    logic        sys_rst_i   = 1'h1;
    logic        req_i       = 1'h0;
    logic        req_write_i = 1'h0;
    logic        mode16_i    = 1'h0;
    logic [7:0]  addr_i      = 8'h00;
    logic [3:0]  be_i        = 4'h0;
    logic [15:0] wdata_i     = 16'h0000;
    logic [1:0]  bus_speed_i = 2'h0;
    logic        rom_start_i = 1'h0;
    logic [31:0] rom_word_i  = 32'hC3A50F96;
    logic        busy_o, done_o, rom_busy_o, rom_present_o, big_endian_o, bus_is16_o;
    logic [15:0] rdata_o;
    logic [31:0] rom_rdata_o;
    logic [7:0]  last_addr_o;
    logic [3:0]  last_be_o;
    int          err_count   = 0;
    int          checks_done = 0;
    // 8-bit rows first: the controller's width comes from its strap, not from mode16_i
    row_t        rows [5] = '{'{1'h0, 8'h11, 4'h0, 16'h00C3, 8'hFF, 16'h00FF},
                              '{1'h0, 8'hFF, 4'h0, 16'h003C, 8'hFF, 16'h00FF},
                              '{1'h1, 8'h04, 4'hF, 16'hA55A, 8'hFC, 16'hFFFF},
                              '{1'h1, 8'hFC, 4'h1, 16'h1234, 8'hFC, 16'hFFFF},
                              '{1'h1, 8'h80, 4'h8, 16'hFFFF, 8'hFC, 16'hFFFF}};
    host_port_if bus_if ();
    // undriven rom data line settles to its strap pull
    assign bus_if.cfg_rom_data_i = bus_if.cfg_rom_data_oe ? bus_if.cfg_rom_data_o
                                                           : bus_if.rom_data_pull;
    host_port_host i_host_port_host (.core_clk_i(core_clk_i), .sys_rst_i(sys_rst_i),
        .bus(bus_if.host), .req_i(req_i), .req_write_i(req_write_i), .mode16_i(mode16_i),
        .addr_i(addr_i), .be_i(be_i), .wdata_i(wdata_i), .busy_o(busy_o), .done_o(done_o),
        .rdata_o(rdata_o));
    host_port_dev #(.NREG(64)) i_host_port_dev (.core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i), .bus(bus_if.dev), .bus_speed_i(bus_speed_i),
        .rom_start_i(rom_start_i), .rom_word_i(rom_word_i), .rom_busy_o(rom_busy_o),
        .rom_rdata_o(rom_rdata_o), .rom_present_o(rom_present_o),
        .big_endian_o(big_endian_o), .bus_is16_o(bus_is16_o), .last_addr_o(last_addr_o),
        .last_be_o(last_be_o));
    host_port_properties i_host_port_properties (.core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i), .chip_select_n(bus_if.chip_select_n),
        .write_strobe_n(bus_if.write_strobe_n), .read_strobe_n(bus_if.read_strobe_n),
        .cmd_type(bus_if.cmd_type), .dev_bus_oe(bus_if.dev_bus_oe),
        .cfg_rom_clock(bus_if.cfg_rom_clock), .cfg_rom_select(bus_if.cfg_rom_select),
        .cfg_rom_data_oe(bus_if.cfg_rom_data_oe));
    always #4 core_clk_i = ~core_clk_i;
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %0t %s got %0h exp %0h", $time, what, got, exp);
        end
    endtask
    task automatic chk_flag(input logic got, input logic exp, input string what);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("unexpected %0t %s got %b", $time, what, got);
        end
    endtask
    task automatic conclude();
        if (err_count == 0 && checks_done > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic bus_op(input logic w, input row_t r, output int n);
        @(posedge core_clk_i);
        req_i       <= 1'h1;
        req_write_i <= w;
        mode16_i    <= r.m16;
        addr_i      <= r.addr;
        be_i        <= r.be;
        wdata_i     <= r.wd;
        @(posedge core_clk_i);
        req_i <= 1'h0;
        n = 1;
        do
        begin
            @(posedge core_clk_i);
            #1;
            n++;
        end
        while (done_o !== 1'h1 && n < 20);
    endtask
    task automatic set_pulls(input logic d, input logic c, input logic l);
        bus_if.rom_data_pull  = d;
        bus_if.rom_clock_pull = c;
        bus_if.led_pull       = l;
    endtask
    task automatic chk_straps(input logic d, input logic c, input logic l);
        chk_flag(rom_present_o, d, "rom strap");
        chk_flag(big_endian_o, c, "order strap");
        chk_flag(bus_is16_o, l, "width strap");
    endtask
    // two-edge reset with new pulls; pulls are inverted afterwards to prove the hold
    task automatic do_reset(input logic d, input logic c, input logic l);
        set_pulls(d, c, l);
        @(posedge core_clk_i);
        sys_rst_i <= 1'h1;
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'h0;
        #1;
        chk_flag(bus_if.link_led_zero, 1'h1, "led pin in reset");
        @(posedge core_clk_i);
        #1;
        chk_flag(bus_if.link_led_zero, 1'h0, "led pin after reset");
        chk_straps(d, c, l);
        set_pulls(~d, ~c, ~l);
    endtask
    initial
    begin
        #300000;
        err_count++;
        conclude();
    end
    initial
    begin
        int   n, cyc, falls, f1, f2;
        logic prev;
        row_t r;
        set_pulls(1'h1, 1'h0, 1'h0);
        repeat (2) @(posedge core_clk_i);
        sys_rst_i <= 1'h0;
        @(posedge core_clk_i);
        #1;
        chk_straps(1'h1, 1'h0, 1'h0);
        set_pulls(1'h0, 1'h1, 1'h1);
        foreach (rows[i])
        begin
            if (rows[i].m16 !== bus_is16_o)
                do_reset(1'h1, 1'h0, rows[i].m16);
            bus_op(1'h1, rows[i], n);
            chk_val(n, 5, "write latency");
            chk_val(last_addr_o & rows[i].amask, rows[i].addr & rows[i].amask, "addr");
            if (rows[i].m16)
                chk_val(last_be_o, rows[i].be, "enables");
            bus_op(1'h0, rows[i], n);
            chk_val(n, 5, "read latency");
            chk_val(rdata_o & rows[i].rmask, rows[i].wd & rows[i].rmask, "rdata");
        end
        chk_straps(1'h1, 1'h0, 1'h1);
        // request held high while busy must not start a second cycle
        r = '{1'h1, 8'h20, 4'hF, 16'h0F0F, 8'hFC, 16'hFFFF};
        @(posedge core_clk_i);
        req_i       <= 1'h1;
        req_write_i <= 1'h1;
        mode16_i    <= 1'h1;
        addr_i      <= r.addr;
        wdata_i     <= r.wd;
        be_i        <= r.be;
        @(posedge core_clk_i);
        addr_i  <= 8'h24;
        wdata_i <= 16'hBEEF;
        repeat (2) @(posedge core_clk_i);
        req_i <= 1'h0;
        repeat (4) @(posedge core_clk_i);
        #1;
        chk_val(last_addr_o & 8'hFC, 8'h20, "held request");
        bus_op(1'h0, r, n);
        chk_val(rdata_o, 16'h0F0F, "held request data");
        for (int s = 0; s < 2; s++)
        begin
            @(posedge core_clk_i);
            bus_speed_i <= s ? 2'h3 : 2'h0;
            rom_start_i <= 1'h1;
            @(posedge core_clk_i);
            rom_start_i <= 1'h0;
            cyc   = 0;
            falls = 0;
            f1    = 0;
            f2    = 0;
            prev  = bus_if.cfg_rom_clock;
            do
            begin
                @(posedge core_clk_i);
                #1;
                cyc++;
                if (prev === 1'h1 && bus_if.cfg_rom_clock === 1'h0)
                begin
                    falls++;
                    if (falls == 1)
                        f1 = cyc;
                    if (falls == 2)
                        f2 = cyc;
                    if (falls == 1)
                        chk_flag(bus_if.cfg_rom_select, 1'h1, "rom select");
                end
                prev = bus_if.cfg_rom_clock;
            end
            while (rom_busy_o === 1'h1 && cyc < 20000);
            chk_val(falls, 32, "rom bits");
            chk_val(f2 - f1, s ? 500 : 100, "rom clock period");
            chk_val(rom_rdata_o, rom_word_i, "rom data loopback");
            chk_flag(bus_if.cfg_rom_select, 1'h0, "rom deselect");
        end
        @(posedge core_clk_i);
        do_reset(1'h0, 1'h1, 1'h0);
        conclude();
    end
endmodule
